/* spisp_pkg.sv */
// Package: register map, field positions and types of the serial port
package spisp_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SPISP_STAT_OFF = 8'h00;
  localparam logic [7:0] SPISP_CTL1_OFF = 8'h04;
  localparam logic [7:0] SPISP_BUF_OFF = 8'h08;
  localparam logic [7:0] SPISP_ISTAT_OFF = 8'h0c;
  localparam logic [7:0] SPISP_IMASK_OFF = 8'h10;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SPISP_EN_BIT = 15;
  localparam int SPISP_SIDL_BIT = 13;
  localparam int SPISP_OVF_BIT = 6;
  localparam int SPISP_TBF_BIT = 1;
  localparam int SPISP_RBF_BIT = 0;
  localparam int SPISP_IRQ_DONE = 0;
  localparam int SPISP_IRQ_ERR = 1;
  // ----------------------------------------------------------------
  // Reset values and word sizes
  // ----------------------------------------------------------------
  localparam logic [10:0] SPISP_CTL_RST = 11'h000;
  localparam logic [15:0] SPISP_WORD_RST = 16'h0000;
  localparam logic [4:0] SPISP_BYTE_LAST = 5'h07;
  localparam logic [4:0] SPISP_WORD_LAST = 5'h0f;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Control register one, bits 10..0
  typedef struct packed {
    logic wide;
    logic sample_phase;
    logic clock_edge;
    logic select_pin_enable;
    logic rsvd6;
    logic master_select;
    logic [2:0] sec_pre;
    logic [1:0] pri_pre;
  } spisp_ctl_t;
  typedef enum logic {SPISP_IDLE, SPISP_SHIFT} spisp_state_t;
endpackage

/* spisp_top.sv */
// Module: serial peripheral port with APB registers
`timescale 1ns/10ps
module spisp_top import spisp_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic device_idle_in,
  input wire logic serial_in_pin_in,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe_out,
  input wire logic shift_clock_pin_in,
  output logic shift_clock_pin_out,
  output logic shift_clock_pin_oe_out,
  input wire logic select_n_pin_in,
  output logic xfer_irq_out,
  output logic err_irq_out,
  output logic irq_out
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Shift clock half period in clk cycles: primary 4**code times secondary code plus one
  function automatic logic [9:0] spisp_div(input logic [1:0] pri, input logic [2:0] sec);
    logic [9:0] p;
    p = 10'h001 << {pri, 1'b0};
    return 10'(p * ({7'h00, sec} + 10'h001));
  endfunction
  // Address decode, used only for the error answer; read data decodes separately
  function automatic logic spisp_hit(input logic [ADDR_W-1:0] a);
    return a == ADDR_W'(SPISP_STAT_OFF) || a == ADDR_W'(SPISP_CTL1_OFF) ||
      a == ADDR_W'(SPISP_BUF_OFF) || a == ADDR_W'(SPISP_ISTAT_OFF) ||
      a == ADDR_W'(SPISP_IMASK_OFF);
  endfunction

  spisp_ctl_t ctl_reg;
  spisp_state_t state_reg;
  logic en_reg, sidl_reg, ovf_reg, tx_full_reg, rx_full_reg, sck_reg, phase_reg;
  logic [15:0] tx_buf_reg, rx_buf_reg, sr_reg;
  logic [4:0] bitcnt_reg;
  logic [9:0] div_cnt_reg;
  logic [1:0] irq_st_reg, irq_mask_reg;
  logic [31:0] prdata_reg;
  logic sck_s1, sck_s2, sck_s3, sdi_s1, sdi_s2, ss_s1, ss_s2, sample_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic acc, wr, wr_stat, wr_buf, rd_buf;
  assign acc = psel_in & penable_in;
  assign wr = acc & pwrite_in;
  assign wr_stat = wr && paddr_in == ADDR_W'(SPISP_STAT_OFF);
  assign wr_buf = wr && paddr_in == ADDR_W'(SPISP_BUF_OFF);
  assign rd_buf = acc && !pwrite_in && paddr_in == ADDR_W'(SPISP_BUF_OFF);
  assign pready_out = acc;
  assign pslverr_out = acc & ~spisp_hit(paddr_in);
  assign prdata_out = prdata_reg;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Third clock stage feeds the edge detector so the first stage stays clean
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {sdi_s1, sdi_s2} <= 2'h0;
      {ss_s1, ss_s2} <= 2'h3;
    end else begin
      {sck_s1, sck_s2, sck_s3} <= {shift_clock_pin_in, sck_s1, sck_s2};
      {sdi_s1, sdi_s2} <= {serial_in_pin_in, sdi_s1};
      {ss_s1, ss_s2} <= {select_n_pin_in, ss_s1};
    end
  end

  // ----------------------------------------------------------------
  // Shift events
  // ----------------------------------------------------------------
  logic active, sel_ok, tick, rise_ev, fall_ev, last_bit, done_ev, load_ev, ovf_ev;
  logic [15:0] rx_word;
  assign active = en_reg & ~(sidl_reg & device_idle_in) & ~ovf_reg;
  assign sel_ok = ~ctl_reg.select_pin_enable | ~ss_s2;
  assign tick = state_reg == SPISP_SHIFT &&
    div_cnt_reg == spisp_div(ctl_reg.pri_pre, ctl_reg.sec_pre) - 10'h001;
  // Master makes its own edges; slave follows the synchronised pin
  always_comb begin
    if (ctl_reg.master_select) begin
      rise_ev = active & tick & ~sck_reg;
      fall_ev = active & tick & sck_reg;
    end else begin
      rise_ev = active & sel_ok & sck_s2 & ~sck_s3;
      fall_ev = active & sel_ok & ~sck_s2 & sck_s3;
    end
  end
  assign last_bit = bitcnt_reg == (ctl_reg.wide ? SPISP_WORD_LAST : SPISP_BYTE_LAST);
  assign done_ev = fall_ev & last_bit;
  // Right-align a byte so the upper half reads as zero
  assign rx_word = ctl_reg.wide ? {sr_reg[14:0], sample_reg} :
    {8'h00, sr_reg[6:0], sample_reg};
  assign ovf_ev = done_ev & rx_full_reg & ~rd_buf;
  // Fresh word enters when idle between words, or straight after a word ends
  always_comb begin
    if (!tx_full_reg || !active)
      load_ev = 1'b0;
    else if (done_ev)
      load_ev = 1'b1;
    else if (ctl_reg.master_select)
      load_ev = state_reg == SPISP_IDLE;
    else
      load_ev = bitcnt_reg == 5'h00 && !phase_reg && !fall_ev;
  end

  // ----------------------------------------------------------------
  // Shift register and bit counter
  // ----------------------------------------------------------------
  // Bits are sampled on the rising edge and shifted in on the falling one
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sr_reg <= SPISP_WORD_RST;
      sample_reg <= 1'b0;
      phase_reg <= 1'b0;
      bitcnt_reg <= 5'h00;
    end else if (!en_reg || (!ctl_reg.master_select && !sel_ok)) begin
      bitcnt_reg <= 5'h00; // Deselect aborts a half-done word
      phase_reg <= 1'b0;
    end else begin
      if (rise_ev) begin
        sample_reg <= sdi_s2;
        phase_reg <= 1'b1;
      end
      if (fall_ev) begin
        phase_reg <= 1'b0;
        bitcnt_reg <= done_ev ? 5'h00 : bitcnt_reg + 5'h01;
      end
      if (load_ev)
        sr_reg <= tx_buf_reg;
      else if (fall_ev)
        sr_reg <= {sr_reg[14:0], sample_reg};
    end
  end

  // ----------------------------------------------------------------
  // Master clock generator
  // ----------------------------------------------------------------
  // A held port freezes the clock in place rather than cutting a bit short
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= SPISP_IDLE;
      sck_reg <= 1'b0;
      div_cnt_reg <= 10'h000;
    end else if (!en_reg || !ctl_reg.master_select) begin
      state_reg <= SPISP_IDLE;
      sck_reg <= 1'b0;
      div_cnt_reg <= 10'h000;
    end else if (active) begin
      unique case (state_reg)
        SPISP_IDLE: begin
          div_cnt_reg <= 10'h000;
          if (load_ev)
            state_reg <= SPISP_SHIFT;
        end
        SPISP_SHIFT: begin
          div_cnt_reg <= tick ? 10'h000 : div_cnt_reg + 10'h001;
          if (tick)
            sck_reg <= ~sck_reg;
          if (done_ev && !load_ev)
            state_reg <= SPISP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Buffers and overflow
  // ----------------------------------------------------------------
  // A new event wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_buf_reg <= SPISP_WORD_RST;
      tx_full_reg <= 1'b0;
      rx_buf_reg <= SPISP_WORD_RST;
      rx_full_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      if (wr_buf) begin
        tx_buf_reg <= pwdata_in[15:0];
        tx_full_reg <= 1'b1;
      end else if (load_ev) begin
        tx_full_reg <= 1'b0;
      end
      if (done_ev && !ovf_ev) begin
        rx_buf_reg <= rx_word;
        rx_full_reg <= 1'b1;
      end else if (rd_buf) begin
        rx_full_reg <= 1'b0;
      end
      if (ovf_ev)
        ovf_reg <= 1'b1;
      else if (wr_stat && !pwdata_in[SPISP_OVF_BIT])
        ovf_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      en_reg <= 1'b0;
      sidl_reg <= 1'b0;
      ctl_reg <= SPISP_CTL_RST;
      irq_mask_reg <= 2'h0;
    end else if (wr) begin
      if (paddr_in == ADDR_W'(SPISP_STAT_OFF)) begin
        en_reg <= pwdata_in[SPISP_EN_BIT];
        sidl_reg <= pwdata_in[SPISP_SIDL_BIT];
      end
      if (paddr_in == ADDR_W'(SPISP_CTL1_OFF))
        ctl_reg <= pwdata_in[10:0];
      if (paddr_in == ADDR_W'(SPISP_IMASK_OFF))
        irq_mask_reg <= pwdata_in[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, write one to clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_st_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == SPISP_IRQ_DONE && done_ev) || (i == SPISP_IRQ_ERR && ovf_ev))
          irq_st_reg[i] <= 1'b1;
        else if (wr && paddr_in == ADDR_W'(SPISP_ISTAT_OFF) && pwdata_in[i])
          irq_st_reg[i] <= 1'b0;
      end
    end
  end
  assign xfer_irq_out = irq_st_reg[SPISP_IRQ_DONE] & irq_mask_reg[SPISP_IRQ_DONE];
  assign err_irq_out = irq_st_reg[SPISP_IRQ_ERR] & irq_mask_reg[SPISP_IRQ_ERR];
  assign irq_out = xfer_irq_out | err_irq_out;

  // ----------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel_in && !penable_in) begin
      prdata_reg <= 32'h0000_0000;
      if (paddr_in == ADDR_W'(SPISP_STAT_OFF)) begin
        prdata_reg[SPISP_EN_BIT] <= en_reg;
        prdata_reg[SPISP_SIDL_BIT] <= sidl_reg;
        prdata_reg[SPISP_OVF_BIT] <= ovf_reg;
        prdata_reg[SPISP_TBF_BIT] <= tx_full_reg;
        prdata_reg[SPISP_RBF_BIT] <= rx_full_reg;
      end
      if (paddr_in == ADDR_W'(SPISP_CTL1_OFF))
        prdata_reg[10:0] <= ctl_reg;
      if (paddr_in == ADDR_W'(SPISP_BUF_OFF))
        prdata_reg[15:0] <= rx_buf_reg;
      if (paddr_in == ADDR_W'(SPISP_ISTAT_OFF))
        prdata_reg[1:0] <= irq_st_reg;
      if (paddr_in == ADDR_W'(SPISP_IMASK_OFF))
        prdata_reg[1:0] <= irq_mask_reg;
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign serial_out_pin_out = ctl_reg.wide ? sr_reg[15] : sr_reg[7];
  assign serial_out_pin_oe_out = en_reg & (ctl_reg.master_select | sel_ok);
  assign shift_clock_pin_out = sck_reg;
  assign shift_clock_pin_oe_out = en_reg & ctl_reg.master_select;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  chk_ovf_freeze: assert property (ovf_reg && !wr |=>
    $stable(sr_reg) && $stable(bitcnt_reg) && $stable(sck_reg))
    else $error("Port moved while overflow set");
  chk_ovf_set: assert property (done_ev && rx_full_reg && !rd_buf |=>
    ovf_reg && $stable(rx_buf_reg) && irq_st_reg[SPISP_IRQ_ERR])
    else $error("Overflow not flagged or buffer overwritten");
  chk_rx_copy: assert property (done_ev && !rx_full_reg |=>
    rx_full_reg && rx_buf_reg == $past(rx_word))
    else $error("Received word not copied");
  chk_tx_load: assert property (done_ev && tx_full_reg && !wr_buf |=>
    sr_reg == $past(tx_buf_reg) && !tx_full_reg)
    else $error("Pending transmit word not loaded");
  // Write lands, the pending word loads one cycle later, then shifting starts
  chk_master_start: assert property (wr_buf && en_reg && ctl_reg.master_select &&
    active && state_reg == SPISP_IDLE |=> ##1 state_reg == SPISP_SHIFT)
    else $error("Master did not start after buffer write");
  chk_slave_clock: assert property (!ctl_reg.master_select |->
    !shift_clock_pin_oe_out) else $error("Slave drove shift clock");
  chk_done_flag: assert property (done_ev |=> irq_st_reg[SPISP_IRQ_DONE] &&
    (xfer_irq_out == irq_mask_reg[SPISP_IRQ_DONE]))
    else $error("Completion flag or request wrong");
  chk_word_len: assert property (done_ev |-> bitcnt_reg ==
    (ctl_reg.wide ? 5'h0f : 5'h07)) else $error("Wrong bit count");
  chk_idle_halt: assert property (sidl_reg && device_idle_in && !wr |=>
    $stable(sck_reg) && $stable(sr_reg)) else $error("Port ran while idle");

  cov_master_word: cover property (ctl_reg.master_select && ctl_reg.wide && done_ev);
  cov_slave_byte: cover property (!ctl_reg.master_select && !ctl_reg.wide && done_ev);
  cov_overflow: cover property (ovf_ev);
  cov_back_to_back: cover property (done_ev && load_ev && ctl_reg.master_select);
endmodule

/* spisp_echo_dev.sv */
// Partner model: external serial peripheral that echoes each received word back
`timescale 1ns/10ps
module spisp_echo_dev (
  input wire logic sck_in,
  input wire logic sdo_in,
  input wire logic wide_in,
  input wire logic load_in,
  input wire logic [15:0] load_word_in,
  output logic sdi_out,
  output logic [15:0] word_out
);
  logic bit_reg = 1'b0;
  // ----------------------------------------------------------------
  // Serial side: clock comes from the port, data both ways
  // ----------------------------------------------------------------
  // Sample on the rising shift clock edge
  always @(posedge sck_in) bit_reg <= sdo_in;
  // Shift on the falling edge; the captured bit rings out in the next word
  always @(negedge sck_in or posedge load_in) begin
    if (load_in)
      word_out <= load_word_in;
    else
      word_out <= {word_out[14:0], bit_reg};
  end
  // Most significant bit of the active width leads
  assign sdi_out = wide_in ? word_out[15] : word_out[7];
endmodule

/* spi_serial_port_test.sv */
// Testbench: APB register checks and master transfers against an echo peripheral
`timescale 1ns/10ps
module spi_serial_port_test import spisp_pkg::*;;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic idle = 1'b0;
  logic p_load = 1'b0;
  logic p_wide = 1'b0;
  logic [15:0] p_word = 16'h0000;
  logic [31:0] prdata;
  logic pready, pslverr, sdi, sdo, sdo_oe, sck, sck_oe, xirq, eirq, irq;
  logic [15:0] p_out;
  logic [31:0] rdv;
  logic last_err;
  int num_errors = 0;
  int compares = 0;
  int rises = 0;
  int r0;
  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  always #10 clk_in = ~clk_in;
  always @(posedge sck) rises++;
  spisp_top u_spisp_top (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .device_idle_in(idle), .serial_in_pin_in(sdi), .serial_out_pin_out(sdo),
    .serial_out_pin_oe_out(sdo_oe), .shift_clock_pin_in(1'b0),
    .shift_clock_pin_out(sck), .shift_clock_pin_oe_out(sck_oe),
    .select_n_pin_in(1'b1), .xfer_irq_out(xirq), .err_irq_out(eirq), .irq_out(irq));
  spisp_echo_dev u_spisp_echo_dev (.sck_in(sck), .sdo_in(sdo), .wide_in(p_wide),
    .load_in(p_load), .load_word_in(p_word), .sdi_out(sdi), .word_out(p_out));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("Errors %0d, compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic fail();
    num_errors++;
    print_verdict();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; returns a step after the edge so outputs have settled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    if (i == 16) fail();
    rdv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdv, exp);
  endtask
  // Poll a register bit until set, bounded
  task automatic wait_bit(input logic [7:0] a, input int b);
    int i;
    for (i = 0; i < 200; i++) begin
      apb(1'b0, a, 32'h0);
      if (rdv[b] === 1'b1) break;
    end
    if (i == 200) fail();
  endtask
  // Cycles between two rising shift clock edges
  task automatic meas(input logic [31:0] exp);
    int r, n;
    for (int k = 0; k < 2; k++) begin
      r = rises;
      for (n = 0; n < 200 && rises == r; n++) @(posedge clk_in);
      if (n == 200) fail();
    end
    check(n, exp);
  endtask
  task automatic pload(input logic w, input logic [15:0] d);
    @(posedge clk_in);
    p_wide <= w;
    p_word <= d;
    p_load <= 1'b1;
    @(posedge clk_in);
    p_load <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Main sequence; buffer is never read-modify-written
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    rchk(SPISP_STAT_OFF, 32'h0);
    rchk(SPISP_CTL1_OFF, 32'h0);
    rchk(SPISP_ISTAT_OFF, 32'h0);
    apb(1'b0, 8'h20, 32'hffff);
    check(last_err, 32'h1);
    check(rdv, 32'h0);
    // Byte transfer, primary divide 4, interrupts masked
    pload(1'b0, 16'h003c);
    wr(SPISP_CTL1_OFF, 32'h21);
    check(sck_oe, 32'h0);
    wr(SPISP_STAT_OFF, 32'h8000);
    check(sck_oe, 32'h1);
    check(sdo_oe, 32'h1);
    wr(SPISP_BUF_OFF, 32'ha5);
    meas(32'd8);
    wait_bit(SPISP_ISTAT_OFF, SPISP_IRQ_DONE);
    check(irq, 32'h0);
    check(rises, 32'd8);
    rchk(SPISP_STAT_OFF, 32'h8001);
    rchk(SPISP_BUF_OFF, 32'h3c);
    check(p_out[7:0], 32'ha5);
    wr(SPISP_IMASK_OFF, 32'h3);
    check(irq, 32'h1);
    check(xirq, 32'h1);
    wr(SPISP_ISTAT_OFF, 32'h1);
    check(irq, 32'h0);
    // Two words back to back, second waits in the transmit buffer
    pload(1'b1, 16'hbeef);
    wr(SPISP_CTL1_OFF, 32'h430);
    wr(SPISP_BUF_OFF, 32'h1234);
    wr(SPISP_BUF_OFF, 32'h5678);
    meas(32'd10);
    wait_bit(SPISP_ISTAT_OFF, SPISP_IRQ_DONE);
    wr(SPISP_ISTAT_OFF, 32'h1);
    rchk(SPISP_BUF_OFF, 32'hbeef);
    wait_bit(SPISP_ISTAT_OFF, SPISP_IRQ_DONE);
    wr(SPISP_ISTAT_OFF, 32'h1);
    rchk(SPISP_BUF_OFF, 32'h1234);
    check(p_out, 32'h5678);
    check(rises, 32'd40);
    // Second word lands on an unread buffer: overflow freezes the port
    wr(SPISP_BUF_OFF, 32'h0f0f);
    wait_bit(SPISP_ISTAT_OFF, SPISP_IRQ_DONE);
    wr(SPISP_ISTAT_OFF, 32'h1);
    wr(SPISP_BUF_OFF, 32'hf0f0);
    wait_bit(SPISP_STAT_OFF, SPISP_OVF_BIT);
    check(eirq, 32'h1);
    rchk(SPISP_BUF_OFF, 32'h5678);
    r0 = rises;
    wr(SPISP_BUF_OFF, 32'h1111);
    repeat (100) @(posedge clk_in);
    check(rises, r0);
    wr(SPISP_STAT_OFF, 32'h8000);
    apb(1'b0, SPISP_STAT_OFF, 32'h0);
    check(rdv[SPISP_OVF_BIT], 32'h0);
    // Let any pending word drain, then clear everything
    repeat (400) @(posedge clk_in);
    apb(1'b0, SPISP_BUF_OFF, 32'h0);
    wr(SPISP_ISTAT_OFF, 32'h3);
    check(eirq, 32'h0);
    // Stop while idle holds the shift clock until idle drops
    idle <= 1'b1;
    wr(SPISP_STAT_OFF, 32'ha000);
    r0 = rises;
    wr(SPISP_BUF_OFF, 32'h2222);
    repeat (100) @(posedge clk_in);
    check(rises, r0);
    idle <= 1'b0;
    wait_bit(SPISP_ISTAT_OFF, SPISP_IRQ_DONE);
    check(rises, r0 + 16);
    // Slave set-up: sample phase and edge bits left clear
    wr(SPISP_CTL1_OFF, 32'h0);
    check(sck_oe, 32'h0);
    print_verdict();
  end
endmodule
